/* File: rtl/atwc_defines.vh */
// register offsets, field positions, reset values and constants for the timer
`ifndef ATWC_DEFINES_VH
`define ATWC_DEFINES_VH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define ATWC_OFF_CTRL_A    12'h000
`define ATWC_OFF_CTRL_B    12'h004
`define ATWC_OFF_COUNT     12'h008
`define ATWC_OFF_CMP_A     12'h00C
`define ATWC_OFF_CMP_B     12'h010
`define ATWC_OFF_ASYNC     12'h014
`define ATWC_OFF_GEN       12'h018
`define ATWC_OFF_STATUS    12'h01C

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define ATWC_A_MODE_A_HI   7
`define ATWC_A_MODE_A_LO   6
`define ATWC_A_MODE_B_HI   5
`define ATWC_A_MODE_B_LO   4
`define ATWC_B_FORCE_A     7
`define ATWC_B_FORCE_B     6
`define ATWC_B_MODE_HIGH   3
`define ATWC_GEN_PSR       1
`define ATWC_ASYNC_SEL     0

// ------------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------------
`define ATWC_RST_BYTE      8'h00
`define ATWC_MAX           8'hFF
`define ATWC_BOTTOM        8'h00
`define ATWC_PRE_W         10

`endif

/* File: rtl/atwc_timer.v */
// timer clock selection, prescaler, waveform modes and compare outputs
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
module atwc_timer (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        osc_input_pin,
   input  wire        dir_a,
   input  wire        dir_b,
   output reg         channel_a_output,
   output reg         channel_b_output,
   output wire        pin_a_override,
   output wire        pin_b_override,
   output wire        pin_a_oe_n,
   output wire        pin_b_oe_n,
   output wire        osc_pins_detached,
   output reg         overflow_flag
);
`include "atwc_defines.vh"

   localparam [2:0] WM_NORMAL = 3'h0;
   localparam [2:0] WM_PC_FF  = 3'h1;
   localparam [2:0] WM_CLR_M  = 3'h2;
   localparam [2:0] WM_FP_FF  = 3'h3;
   localparam [2:0] WM_PC_A   = 3'h5;
   localparam [2:0] WM_FP_A   = 3'h7;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg  [1:0]  channel_a_output_mode;
   reg  [1:0]  channel_b_output_mode;
   reg  [1:0]  wgm_low;
   reg         waveform_mode_high_bit;
   reg  [2:0]  clock_divider_select;
   reg         async_clock_select;
   reg  [7:0]  count;
   reg  [7:0]  compare_value_a;
   reg  [7:0]  compare_value_b;
   reg  [7:0]  buf_a;
   reg  [7:0]  buf_b;
   reg         count_down;
   reg  [9:0]  prescale;
   reg         osc_s1;
   reg         osc_s2;
   reg         osc_s3;
   wire [2:0]  waveform_mode;
   wire        is_fast;
   wire        is_pc;
   wire        pwm;
   wire [7:0]  top;
   wire        src_tick;
   reg         tick;
   wire        wr;
   wire        rd;
   wire        psr_req;

   assign waveform_mode = {waveform_mode_high_bit, wgm_low};
   // modes 4 and 6 are reserved and act as normal counting
   assign is_fast = (waveform_mode == WM_FP_FF) ||
                    (waveform_mode == WM_FP_A);
   assign is_pc   = (waveform_mode == WM_PC_FF) ||
                    (waveform_mode == WM_PC_A);
   assign pwm     = is_fast || is_pc;
   assign top     = (waveform_mode == WM_CLR_M || waveform_mode == WM_PC_A ||
                     waveform_mode == WM_FP_A) ? compare_value_a
                                               : `ATWC_MAX;

   // ---------------------------------------------------------------
   // apb slave: zero wait states, no error
   // ---------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr      = psel && penable && pwrite && clk_en;
   assign rd      = psel && !pwrite;
   assign psr_req = wr && (paddr == `ATWC_OFF_GEN) &&
                    pwdata[`ATWC_GEN_PSR];

   // read mux; reserved bits and strobes read zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (clk_en && rd && !penable) begin
         case (paddr)
            `ATWC_OFF_CTRL_A: prdata <= {24'h000000, channel_a_output_mode,
                                  channel_b_output_mode, 2'h0,
                                  wgm_low};
            `ATWC_OFF_CTRL_B: prdata <= {28'h0000000,
                                  waveform_mode_high_bit,
                                  clock_divider_select};
            `ATWC_OFF_COUNT:  prdata <= {24'h000000, count};
            `ATWC_OFF_CMP_A:  prdata <= {24'h000000, buf_a};
            `ATWC_OFF_CMP_B:  prdata <= {24'h000000, buf_b};
            `ATWC_OFF_ASYNC:  prdata <= {31'h00000000, async_clock_select};
            `ATWC_OFF_STATUS: prdata <= {29'h00000000, count_down,
                                  channel_b_output, channel_a_output};
            default:          prdata <= 32'h00000000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // clock source: pclk, or synchronised crystal rising edge
   // ---------------------------------------------------------------
   // the crystal is far slower than pclk, so an edge detect suffices
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
      end else if (clk_en) begin
         osc_s1 <= osc_input_pin;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
      end
   end

   assign src_tick = async_clock_select ? (osc_s2 && !osc_s3) : 1'b1;
   assign osc_pins_detached = async_clock_select;

   // prescaler counter, restarted by the reset strobe
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= 10'h000;
      end else if (clk_en) begin
         if (psr_req) begin
            prescale <= 10'h000;
         end else if (src_tick) begin
            prescale <= prescale + 10'h001;
         end
      end
   end

   // divider choice: tick when the low bits of the prescaler wrap
   always @* begin
      case (clock_divider_select)
         3'h0:    tick = 1'b0;
         3'h1:    tick = src_tick;
         3'h2:    tick = src_tick && (prescale[2:0] == 3'h7);
         3'h3:    tick = src_tick && (prescale[4:0] == 5'h1F);
         3'h4:    tick = src_tick && (prescale[5:0] == 6'h3F);
         3'h5:    tick = src_tick && (prescale[6:0] == 7'h7F);
         3'h6:    tick = src_tick && (prescale[7:0] == 8'hFF);
         default: tick = src_tick && (prescale == 10'h3FF);
      endcase
   end

   // ---------------------------------------------------------------
   // counter and double-buffered compare values
   // ---------------------------------------------------------------
   wire wr_cnt  = wr && (paddr == `ATWC_OFF_COUNT);
   wire at_top  = (count == top);
   wire at_bot  = (count == `ATWC_BOTTOM);
   wire match_a = (count == compare_value_a);
   wire match_b = (count == compare_value_b);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count      <= `ATWC_RST_BYTE;
         count_down <= 1'b0;
      end else if (clk_en) begin
         if (wr_cnt) begin
            count <= pwdata[7:0];
         end else if (tick) begin
            if (is_pc) begin
               if (count_down) begin
                  count <= at_bot ? 8'h01 : count - 8'h01;
                  count_down <= !at_bot;
               end else begin
                  count <= at_top ? count - 8'h01 : count + 8'h01;
                  count_down <= at_top;
               end
            end else begin
               count <= at_top ? `ATWC_BOTTOM : count + 8'h01;
               count_down <= 1'b0;
            end
         end
      end
   end

   // compare update: immediate in non-PWM modes, at TOP in both fast and phase correct PWM
   wire upd_now = !pwm || (tick && (is_pc ? at_top : at_top));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_value_a <= `ATWC_RST_BYTE;
         compare_value_b <= `ATWC_RST_BYTE;
      end else if (clk_en && upd_now) begin
         compare_value_a <= pwm ? buf_a : buf_a;
         compare_value_b <= buf_b;
      end
   end

   // overflow pulse: MAX, BOTTOM in phase correct, TOP in mode 7
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
      end else if (clk_en) begin
         if (is_pc) begin
            overflow_flag <= tick && count_down && at_bot;
         end else if (waveform_mode == WM_FP_A) begin
            overflow_flag <= tick && at_top;
         end else begin
            overflow_flag <= tick && (count == `ATWC_MAX);
         end
      end
   end

   // ---------------------------------------------------------------
   // control register writes
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_a_output_mode  <= 2'h0;
         channel_b_output_mode  <= 2'h0;
         wgm_low                <= 2'h0;
         waveform_mode_high_bit <= 1'b0;
         clock_divider_select   <= 3'h0;
         async_clock_select     <= 1'b0;
         buf_a                  <= `ATWC_RST_BYTE;
         buf_b                  <= `ATWC_RST_BYTE;
      end else if (wr) begin
         case (paddr)
            `ATWC_OFF_CTRL_A: begin
               channel_a_output_mode <= pwdata[7:6];
               channel_b_output_mode <= pwdata[5:4];
               wgm_low               <= pwdata[1:0];
            end
            `ATWC_OFF_CTRL_B: begin
               waveform_mode_high_bit <= pwdata[`ATWC_B_MODE_HIGH];
               clock_divider_select   <= pwdata[2:0];
            end
            `ATWC_OFF_CMP_A:  buf_a <= pwdata[7:0];
            `ATWC_OFF_CMP_B:  buf_b <= pwdata[7:0];
            `ATWC_OFF_ASYNC:
               async_clock_select <= pwdata[`ATWC_ASYNC_SEL];
            default: ;
         endcase
      end
   end

   // force strobes act only in non-PWM modes and read as zero
   wire force_a = wr && (paddr == `ATWC_OFF_CTRL_B) && !pwm &&
                  pwdata[`ATWC_B_FORCE_A];
   wire force_b = wr && (paddr == `ATWC_OFF_CTRL_B) && !pwm &&
                  pwdata[`ATWC_B_FORCE_B];

   // ---------------------------------------------------------------
   // compare output generation, one function for both channels
   // ---------------------------------------------------------------
   // act = {change, value}; chan_a selects the toggle allowance; the
   // counter state comes in as st = {pwm, high mode bit, tick, fast,
   // at top, counting down} so that the caller sees every change of it
   function [1:0] out_act;
      input [1:0] mode;
      input       chan_a;
      input       hit;
      input       cmp_top;
      input       cur;
      input [5:0] st;
      reg   [1:0] r;
      begin
         r = 2'b00;
         if (!st[5]) begin
            if (hit) begin
               case (mode)
                  2'h1:    r = {1'b1, !cur};
                  2'h2:    r = 2'b10;
                  2'h3:    r = 2'b11;
                  default: r = 2'b00;
               endcase
            end
         end else if (mode == 2'h1) begin
            // toggle only channel A with the high mode bit; B is reserved
            if (chan_a && st[4] && hit && st[3])
               r = {1'b1, !cur};
         end else if (mode[1] && st[3]) begin
            if (st[2]) begin
               if (st[1])
                  r = {1'b1, !mode[0]};
               else if (hit && !cmp_top)
                  r = {1'b1, mode[0]};
            end else if (cmp_top) begin
               // level of a down-counting match, so the pin stands still
               if (st[1])
                  r = {1'b1, !mode[0]};
            end else if (hit) begin
               r = {1'b1, mode[0] ^ st[0]};
            end
         end
         out_act = r;
      end
   endfunction

   wire [5:0] wave_state = {pwm, waveform_mode_high_bit, tick, is_fast,
                            at_top, count_down};
   wire [1:0] act_a = out_act(channel_a_output_mode, 1'b1,
                              force_a || (match_a && (tick || pwm)),
                              compare_value_a == top, channel_a_output,
                              wave_state);
   wire [1:0] act_b = out_act(channel_b_output_mode, 1'b0,
                              force_b || (match_b && (tick || pwm)),
                              compare_value_b == top, channel_b_output,
                              wave_state);

   // outputs change only when an action is due
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_a_output <= 1'b0;
         channel_b_output <= 1'b0;
      end else if (clk_en) begin
         if (act_a[1])
            channel_a_output <= act_a[0];
         if (act_b[1])
            channel_b_output <= act_b[0];
      end
   end

   // pin takeover and driver enable (enable is active low)
   assign pin_a_override = |channel_a_output_mode;
   assign pin_b_override = |channel_b_output_mode;
   assign pin_a_oe_n     = !(pin_a_override && dir_a);
   assign pin_b_oe_n     = !(pin_b_override && dir_b);

endmodule // atwc_timer

/* File: verification/atwc_checker.sv */
// concurrent checks on the timer's bus, pin control and overflow ports
`timescale 1ns/10ps
`include "atwc_defines.vh"
module atwc_checker (
   input logic        pclk,
   input logic        presetn,
   input logic        clk_en,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        dir_a,
   input logic        dir_b,
   input logic        pin_a_override,
   input logic        pin_b_override,
   input logic        pin_a_oe_n,
   input logic        pin_b_oe_n,
   input logic        osc_pins_detached,
   input logic        overflow_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   reg wgm_hi;
   // shadow of the high mode bit, so readback can be judged
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wgm_hi <= 1'b0;
      else if (psel && penable && pwrite && clk_en && paddr == `ATWC_OFF_CTRL_B)
         wgm_hi <= pwdata[3];
   end
   // ------------------------------------------------------------------
   // bus access steps
   // ------------------------------------------------------------------
   sequence acc(logic w, logic [11:0] a);
      psel && penable && pwrite == w && clk_en && paddr == a;
   endsequence
   a_override_a: assert property (acc(1'b1, `ATWC_OFF_CTRL_A) |=>
      pin_a_override == ($past(pwdata[7:6]) != 2'b00)) else $error("override a");
   b_override_a: assert property (acc(1'b1, `ATWC_OFF_CTRL_A) |=>
      pin_b_override == ($past(pwdata[5:4]) != 2'b00)) else $error("override b");
   a_driver_a: assert property (pin_a_oe_n == !(pin_a_override && dir_a))
      else $error("driver enable a");
   b_driver_a: assert property (pin_b_oe_n == !(pin_b_override && dir_b))
      else $error("driver enable b");
   pin_detach_a: assert property (acc(1'b1, `ATWC_OFF_ASYNC) |=>
      osc_pins_detached == $past(pwdata[0])) else $error("pin detach");
   ctrl_rsvd_a: assert property (acc(1'b0, `ATWC_OFF_CTRL_A) |->
      prdata[3:2] == 2'b00 && prdata[31:8] == 24'h0) else $error("reserved");
   mode_high_a: assert property (acc(1'b0, `ATWC_OFF_CTRL_B) |->
      prdata[3] == wgm_hi && prdata[7:6] == 2'b00) else $error("high mode");
   ovf_pulse_a: assert property (overflow_flag |=> !overflow_flag)
      else $error("overflow pulse");
endmodule // atwc_checker

bind atwc_timer atwc_checker chk (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .dir_a(dir_a),
   .dir_b(dir_b), .pin_a_override(pin_a_override),
   .pin_b_override(pin_b_override), .pin_a_oe_n(pin_a_oe_n),
   .pin_b_oe_n(pin_b_oe_n), .osc_pins_detached(osc_pins_detached),
   .overflow_flag(overflow_flag));

/* File: verification/atwc_pin_model.sv */
// crystal and port pad model at the timer's far side
`timescale 1ns/10ps
module atwc_pin_model #(
   parameter real HALF_NS = 15259.0
) (
   output logic osc,
   input  logic oe_a_n,
   input  logic oe_b_n,
   input  logic level_a,
   input  logic level_b,
   output logic pad_a,
   output logic pad_b
);
   // a crystal oscillates freely, it never pauses between uses
   initial begin
      osc = 1'b0;
      forever #(HALF_NS) osc = ~osc;
   end
   // undriven pads float up to the pull-up level
   assign pad_a = oe_a_n ? 1'b1 : level_a;
   assign pad_b = oe_b_n ? 1'b1 : level_b;
endmodule // atwc_pin_model

/* File: verification/atwc_timer_bench.sv */
// self-checking bench for the timer through its register bus and pins
`timescale 1ns/10ps
`include "atwc_defines.vh"
module atwc_timer_bench;
   localparam [11:0] oa = `ATWC_OFF_CTRL_A, ob = `ATWC_OFF_CTRL_B;
   localparam [11:0] oc = `ATWC_OFF_COUNT, oas = `ATWC_OFF_ASYNC;
   localparam [11:0] ca = `ATWC_OFF_CMP_A, cb = `ATWC_OFF_CMP_B;
   logic        pclk, presetn, clk_en, psel, penable, pwrite, dir_a, dir_b;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd, prdata;
   wire         pready, osc, out_a, out_b, ovr_a, ovr_b, oe_a_n, oe_b_n;
   wire         det, ovf, pad_a, pad_b, slverr;
   int          errors, num_checks, k, n, m;
   int          dv[7] = '{1, 8, 32, 64, 128, 256, 1024};
   int          wg[6] = '{0, 1, 2, 3, 5, 7};
   int          lo[6] = '{3, 1, 0, 3, 4, 9};
   int          hi[6] = '{4, 2, 0, 4, 6, 10};
   int          pw[4] = '{3, 1, 3, 1};
   int          pv[4] = '{64, 64, 255, 255};
   int          wn[4] = '{1024, 1020, 1024, 1020};
   int          pl[4] = '{250, 250, 1024, 1020};
   int          ph[4] = '{262, 262, 1024, 1020};
   int          fc[4] = '{3, 2, 1, 1};
   int          fe[4] = '{1, 0, 1, 0};
   atwc_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(slverr),
      .osc_input_pin(osc), .dir_a(dir_a), .dir_b(dir_b),
      .channel_a_output(out_a), .channel_b_output(out_b),
      .pin_a_override(ovr_a), .pin_b_override(ovr_b), .pin_a_oe_n(oe_a_n),
      .pin_b_oe_n(oe_b_n), .osc_pins_detached(det), .overflow_flag(ovf));
   atwc_pin_model pins (.osc(osc), .oe_a_n(oe_a_n), .oe_b_n(oe_b_n),
      .level_a(out_a), .level_b(out_b), .pad_a(pad_a), .pad_b(pad_b));
   // ------------------------------------------------------------------
   // bus master and comparisons
   // ------------------------------------------------------------------
   // request held until pready is seen high, released only after it
   task automatic xfer(input logic w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input [11:0] a, input [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h wanted %h", $time, got, exp);
      end
   endtask
   // ranges absorb the unknown phase of the divided tick
   task automatic chkr(input logic [31:0] got, input int l, input int h);
      num_checks++;
      if ($isunknown(got) || got < l || got > h) begin
         errors++;
         $display("CHECK FAILED at %0t: %0d not in %0d..%0d", $time, got, l, h);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // watchdog sized well above the roughly 50k cycles of the tests
   initial begin
      #(90000 * 50);
      errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_of_test;
   end
   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      {presetn, clk_en, psel, penable, pwrite, dir_a, dir_b} = 7'b0100000;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (k = 0; k < 9; k++) begin
         xfer(1'b0, 12'(k * 4), 32'h0);
         chk(rd, 32'h0);
         chk({pready, slverr}, 2'b10);
      end
      wr(oa, 32'h000000FF);
      xfer(1'b0, oa, 32'h0);
      chk(rd, 32'h000000F3);
      wr(ob, 32'h000000C8);
      xfer(1'b0, ob, 32'h0);
      chk(rd, 32'h00000008);
      wr(ob, 32'h0);
      $display("test registers done");
      for (k = 0; k < 8; k++) begin
         dir_a <= k[2];
         dir_b <= !k[2];
         wr(oa, {24'h0, k[1:0], k[1:0], 4'h0});
         @(negedge pclk);
         chk(ovr_a, k[1:0] != 2'b00);
         chk(oe_a_n, !(k[1:0] != 2'b00 && k[2]));
         chk(oe_b_n, !(k[1:0] != 2'b00 && !k[2]));
         if (!oe_a_n) chk(pad_a, out_a);
         chk(ovr_b, k[1:0] != 2'b00);
         if (!oe_b_n) chk(pad_b, out_b);
      end
      $display("test pin override done");
      for (k = 0; k < 4; k++) begin
         wr(oa, {24'h0, 2'(fc[k]), 2'(fc[k]), 4'h0});
         wr(ob, 32'h000000C0);
         @(negedge pclk);
         chk(out_a, fe[k][0]);
         chk(out_b, fe[k][0]);
      end
      $display("test forced codes done");
      wr(oa, 32'h0);
      for (k = 0; k < 7; k++) begin
         wr(oc, 32'h0);
         wr(`ATWC_OFF_GEN, 32'h00000002);
         wr(ob, 32'(k + 1));
         repeat (20 * dv[k]) @(posedge pclk);
         wr(ob, 32'h0);
         xfer(1'b0, oc, 32'h0);
         chkr(rd, 19, 24);
         n = rd;
         repeat (50) @(posedge pclk);
         xfer(1'b0, oc, 32'h0);
         chk(rd, n);
      end
      $display("test divider done");
      wr(ca, 32'd99);
      for (k = 0; k < 6; k++) begin
         wr(ob, 32'h0);
         wr(oc, 32'h0);
         wr(oa, 32'(wg[k] & 3));
         wr(ob, 32'((wg[k] & 4) << 1 | 1));
         n = 0;
         repeat (1000) @(negedge pclk) if (ovf === 1'b1) n++;
         chkr(n, lo[k], hi[k]);
      end
      $display("test overflow done");
      for (k = 0; k < 4; k++) begin
         wr(ob, 32'h0);
         wr(oc, 32'h0);
         wr(ca, pv[k]);
         wr(cb, pv[k]);
         wr(oa, 32'h000000B0 | pw[k]);
         wr(ob, 32'h1);
         repeat (600) @(posedge pclk);
         n = 0;
         m = 0;
         repeat (wn[k]) begin
            @(negedge pclk);
            if (out_a === 1'b1) n++;
            if (out_b !== !out_a) m++;
         end
         chkr(n, pl[k], ph[k]);
         chk(m, 32'h0);
      end
      $display("test waveform done");
      wr(ob, 32'h0);
      wr(oas, 32'h1);
      @(negedge pclk);
      chk(det, 1'b1);
      wr(oa, 32'h0);
      wr(oc, 32'h0);
      wr(ob, 32'h1);
      repeat (1900) @(posedge pclk);
      wr(ob, 32'h0);
      xfer(1'b0, oc, 32'h0);
      chkr(rd, 2, 4);
      wr(oas, 32'h0);
      @(negedge pclk);
      chk(det, 1'b0);
      $display("test crystal done");
      // a frozen block must not take a register write
      @(posedge pclk);
      clk_en <= 1'b0;
      wr(oa, 32'h00000040);
      @(posedge pclk);
      clk_en <= 1'b1;
      xfer(1'b0, oa, 32'h0);
      chk(rd, 32'h0);
      $display("test freeze done");
      end_of_test;
   end
endmodule // atwc_timer_bench
